// >>> shared/lsif_regs.vh
// Register indices, field positions, reset values and timing counts of the
// line status and event flag block.
// Assumes a 32-bit Avalon-MM register port where byte address = 4 * index.
`ifndef LSIF_REGS_VH
`define LSIF_REGS_VH

// Register indices; the byte address on the bus is four times the index.
`define LSIF_IDX_LINE_STATUS_0 8'h17
`define LSIF_IDX_LINE_STATUS_1 8'h18
`define LSIF_IDX_EVENT_FLAGS_0 8'h19
`define LSIF_IDX_EVENT_MASK_0 8'h20
`define LSIF_IDX_EDGE_SEL_0 8'h21

// Fields of line_status_0; event_flags_0, mask and edge select share them.
`define LSIF_BIT_EQUALIZER_RANGE 7
`define LSIF_BIT_LOOP_ACTIVATE 6
`define LSIF_BIT_LOOP_DEACTIVATE 5
`define LSIF_BIT_PATTERN_SYNC 4
`define LSIF_BIT_TX_CLOCK_LOSS 3
`define LSIF_BIT_DRIVER_FAULT 2
`define LSIF_BIT_ALARM_SIGNAL 1
`define LSIF_BIT_SIGNAL_LOSS 0

// Fields of line_status_1.
`define LSIF_BIT_FAR_LOOPBACK 5
`define LSIF_ATTEN_MSB 4
`define LSIF_ATTEN_LSB 0

// Reset values.
`define LSIF_RST_STATUS 8'h00
`define LSIF_RST_EVENT_FLAGS 8'h00
`define LSIF_RST_EVENT_MASK 8'hff
`define LSIF_RST_EDGE_SEL 8'h00

// Master clock cycles without a transmit clock toggle before loss is flagged.
`define LSIF_TX_CLOCK_LOSS_CYCLES 70

`endif

// >>> rtl/lsif_event_detect.v
// Per-source event detector: turns status bit changes into event pulses.
// Assumes status bits are registered and synchronous to clk.
`timescale 1ns/1ps
module lsif_event_detect #(
	parameter WIDTH = 8
) (
	input wire clk,
	input wire sys_rst,
	input wire [WIDTH-1:0] status,
	input wire [WIDTH-1:0] mask,
	input wire [WIDTH-1:0] edge_sel,
	output wire [WIDTH-1:0] event_pulse
);

	reg [WIDTH-1:0] prev_reg;

	always @(posedge clk) begin
		if (sys_rst) begin
			prev_reg <= {WIDTH{1'b0}};
		end else begin
			prev_reg <= status;
		end
	end

	////////////////////////////////////////////////////////////////////////
	genvar i;
	generate
		for (i = 0; i < WIDTH; i = i + 1) begin : g_src
			wire rise;
			wire fall;
			assign rise = status[i] & ~prev_reg[i];
			assign fall = ~status[i] & prev_reg[i];
			// A masked source never raises an event, whatever its edge select.
			assign event_pulse[i] = ~mask[i] & (rise | (edge_sel[i] & fall));
		end
	endgenerate

endmodule

// >>> rtl/lsif_line_status_flags.v
// What this block does
// - Status bit 2 shows a line driver short circuit, clear in normal operation.
// - Status bit 1 is set while alarm indication signal is received.
// - Status bit 0 is set while loss of signal on the receive pair.
// - Edge select zero: event only on a rising status bit.
// - Edge select one: event on every rising or falling status change.
// - Mask zero lets a source raise events; mask one suppresses them.
// - Both line status registers are real time, read only, indices 17h and 18h.
// - Second status bit 5 is set while the remote loopback is closed.
// - Reading event flags at index 19h clears them; all reset to zero.
// - Event flag bit 7 latches equalizer out-of-range events.
// - Event flag bit 6 latches loopback activate code events.
// - Event flag bit 5 latches loopback deactivate code events.
// - Event flag bit 4 latches pattern synchronisation events.
// - Event flag bit 3 latches transmit clock loss events.
// - Event flag bit 2 latches line driver failure events.
// - Event flag bit 1 latches alarm indication signal events.
// - Event flag bit 0 latches loss-of-signal events.
// - Transmit clock loss sets after more than 70 cycles without toggle.
//
// Top of the line status and event flag block, with its Avalon-MM slave.
// Assumes all condition inputs and the transmit clock pin are synchronous
// to clk, and that the master keeps a request steady until waitrequest is low.
`timescale 1ns/1ps
`include "lsif_regs.vh"
module lsif_line_status_flags #(
	parameter LOSS_CYCLES = `LSIF_TX_CLOCK_LOSS_CYCLES
) (
	input wire clk,
	input wire sys_rst,
	input wire [9:0] avs_address,
	input wire avs_read,
	input wire avs_write,
	input wire [31:0] avs_writedata,
	input wire [3:0] avs_byteenable,
	output wire [31:0] avs_readdata,
	output wire avs_waitrequest,
	input wire driver_fault_in,
	input wire alarm_signal_in,
	input wire rx_line_pair_loss_in,
	input wire equalizer_out_of_range_in,
	input wire loop_activate_in,
	input wire loop_deactivate_in,
	input wire pattern_sync_in,
	input wire far_loopback_in,
	input wire [4:0] cable_attenuation_in,
	input wire tx_clock_pin,
	output wire irq_req
);

	// The idle counter is seven bits wide, so the limit is cut to that width on purpose.
	localparam [6:0] LOSS_LIMIT = LOSS_CYCLES[6:0];
	localparam [6:0] LOSS_SATURATE = LOSS_LIMIT + 7'h01;

	////////////////////////////////////////////////////////////////////////
	// Transmit clock watchdog.

	reg tx_clock_prev_reg;
	reg [6:0] tx_idle_count_reg;
	reg [6:0] tx_idle_count_next;
	wire tx_clock_toggled;
	wire tx_clock_loss_state;

	assign tx_clock_toggled = tx_clock_pin ^ tx_clock_prev_reg;

	always @* begin
		if (tx_clock_toggled) begin
			tx_idle_count_next = 7'h00;
		end else if (tx_idle_count_reg == LOSS_SATURATE) begin
			// Saturate one past the limit so the flag holds without wrapping.
			tx_idle_count_next = tx_idle_count_reg;
		end else begin
			tx_idle_count_next = tx_idle_count_reg + 7'h01;
		end
	end

	always @(posedge clk) begin
		if (sys_rst) begin
			tx_clock_prev_reg <= 1'b0;
			tx_idle_count_reg <= 7'h00;
		end else begin
			tx_clock_prev_reg <= tx_clock_pin;
			tx_idle_count_reg <= tx_idle_count_next;
		end
	end

	assign tx_clock_loss_state = (tx_idle_count_reg > LOSS_LIMIT);

	////////////////////////////////////////////////////////////////////////
	// Real-time status, sampled every cycle and never latched.

	reg [7:0] line_status_0_reg;
	reg [7:0] line_status_0_next;
	reg [7:0] line_status_1_reg;
	reg [7:0] line_status_1_next;

	always @* begin
		line_status_0_next = `LSIF_RST_STATUS;
		line_status_0_next[`LSIF_BIT_EQUALIZER_RANGE] = equalizer_out_of_range_in;
		line_status_0_next[`LSIF_BIT_LOOP_ACTIVATE] = loop_activate_in;
		line_status_0_next[`LSIF_BIT_LOOP_DEACTIVATE] = loop_deactivate_in;
		line_status_0_next[`LSIF_BIT_PATTERN_SYNC] = pattern_sync_in;
		line_status_0_next[`LSIF_BIT_TX_CLOCK_LOSS] = tx_clock_loss_state;
		line_status_0_next[`LSIF_BIT_DRIVER_FAULT] = driver_fault_in;
		line_status_0_next[`LSIF_BIT_ALARM_SIGNAL] = alarm_signal_in;
		line_status_0_next[`LSIF_BIT_SIGNAL_LOSS] = rx_line_pair_loss_in;
	end

	always @* begin
		// Bits 7 and 6 are reserved and stay zero.
		line_status_1_next = `LSIF_RST_STATUS;
		line_status_1_next[`LSIF_BIT_FAR_LOOPBACK] = far_loopback_in;
		// Codes above the top step all mean more than 44 dB; passed unchanged.
		line_status_1_next[`LSIF_ATTEN_MSB:`LSIF_ATTEN_LSB] = cable_attenuation_in;
	end

	always @(posedge clk) begin
		if (sys_rst) begin
			line_status_0_reg <= `LSIF_RST_STATUS;
			line_status_1_reg <= `LSIF_RST_STATUS;
		end else begin
			line_status_0_reg <= line_status_0_next;
			line_status_1_reg <= line_status_1_next;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Bus slave: one wait state on every access, registered read data.

	reg ack_reg;
	reg [7:0] readdata_reg;
	reg [7:0] readdata_next;
	reg [7:0] event_mask_reg;
	reg [7:0] edge_sel_reg;
	wire [7:0] bus_index;
	wire request;
	wire read_taken;
	wire write_taken;
	wire flags_read_taken;

	assign bus_index = avs_address[9:2];
	assign request = avs_read | avs_write;
	assign avs_waitrequest = request & ~ack_reg;
	assign read_taken = avs_read & ack_reg;
	assign write_taken = avs_write & ack_reg & avs_byteenable[0];
	assign flags_read_taken = read_taken && (bus_index == `LSIF_IDX_EVENT_FLAGS_0);

	always @(posedge clk) begin
		if (sys_rst) begin
			ack_reg <= 1'b0;
		end else begin
			ack_reg <= request & ~ack_reg;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Event flags.

	reg [7:0] event_flags_reg;
	reg [7:0] event_flags_next;
	reg [7:0] flags_clear;
	wire [7:0] event_pulse;

	lsif_event_detect #(
		.WIDTH(8)
	) u_event_detect (
		.clk(clk),
		.sys_rst(sys_rst),
		.status(line_status_0_reg),
		.mask(event_mask_reg),
		.edge_sel(edge_sel_reg),
		.event_pulse(event_pulse)
	);

	always @* begin
		// Only bits that software has actually seen are cleared, so an event
		// that lands between the data capture and the end of the read survives.
		if (flags_read_taken) begin
			flags_clear = readdata_reg;
		end else begin
			flags_clear = 8'h00;
		end
		// A new event wins over a clear in the same cycle.
		event_flags_next = (event_flags_reg & ~flags_clear) | event_pulse;
	end

	always @(posedge clk) begin
		if (sys_rst) begin
			event_flags_reg <= `LSIF_RST_EVENT_FLAGS;
		end else begin
			// Each bit latches its own source: bit 7 equalizer, 6 activate,
			// 5 deactivate, 4 pattern, 3 tx clock, 2 driver, 1 alarm, 0 loss.
			event_flags_reg <= event_flags_next;
		end
	end

	assign irq_req = |event_flags_reg;

	////////////////////////////////////////////////////////////////////////
	// Mask and edge select registers.

	always @(posedge clk) begin
		if (sys_rst) begin
			event_mask_reg <= `LSIF_RST_EVENT_MASK;
			edge_sel_reg <= `LSIF_RST_EDGE_SEL;
		end else if (write_taken) begin
			if (bus_index == `LSIF_IDX_EVENT_MASK_0) begin
				event_mask_reg <= avs_writedata[7:0];
			end
			if (bus_index == `LSIF_IDX_EDGE_SEL_0) begin
				edge_sel_reg <= avs_writedata[7:0];
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Read data path. Data is captured in the wait cycle and held for the
	// cycle in which waitrequest is low; writes to status are ignored.

	always @* begin
		case (bus_index)
			`LSIF_IDX_LINE_STATUS_0: begin
				readdata_next = line_status_0_reg;
			end
			`LSIF_IDX_LINE_STATUS_1: begin
				readdata_next = line_status_1_reg;
			end
			`LSIF_IDX_EVENT_FLAGS_0: begin
				readdata_next = event_flags_reg;
			end
			`LSIF_IDX_EVENT_MASK_0: begin
				readdata_next = event_mask_reg;
			end
			`LSIF_IDX_EDGE_SEL_0: begin
				readdata_next = edge_sel_reg;
			end
			default: begin
				readdata_next = 8'h00;
			end
		endcase
	end

	always @(posedge clk) begin
		if (sys_rst) begin
			readdata_reg <= 8'h00;
		end else if (avs_read & ~ack_reg) begin
			readdata_reg <= readdata_next;
		end
	end

	assign avs_readdata = {24'h000000, readdata_reg};

endmodule

// >>> tb/lsif_line_status_flags_assertions.sv
// Checker for the line status and event flag block, bound to its top module.
// Assumes the one wait state register bus timing of the block.
`timescale 1ns/1ps
`include "lsif_regs.vh"
module lsif_flags_chk #(
	parameter LOSS_CYCLES = 70
) (
	input wire clk,
	input wire sys_rst,
	input wire [9:0] avs_address,
	input wire avs_read,
	input wire avs_write,
	input wire [31:0] avs_readdata,
	input wire avs_waitrequest,
	input wire driver_fault_in,
	input wire alarm_signal_in,
	input wire rx_line_pair_loss_in,
	input wire far_loopback_in,
	input wire [4:0] cable_attenuation_in,
	input wire irq_req
);
	// Inputs are registered into status one edge before read data is captured, which is one edge before the taking edge, hence the depth of two.
	wire rd_done = avs_read && !avs_waitrequest;
	wire [7:0] idx = avs_address[9:2];
	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);
	sequence s_req_rise;
		$rose(avs_read) || $rose(avs_write);
	endsequence
	sequence s_one_wait;
		avs_waitrequest ##1 !avs_waitrequest;
	endsequence
	a_one_wait:
		assert property (s_req_rise |-> s_one_wait) else $error("bus wait state count wrong");
	a_df_status:
		assert property (rd_done && idx == `LSIF_IDX_LINE_STATUS_0
			|-> avs_readdata[2] == $past(driver_fault_in, 2)) else $error("driver fault bit wrong");
	a_ais_status:
		assert property (rd_done && idx == `LSIF_IDX_LINE_STATUS_0
			|-> avs_readdata[1] == $past(alarm_signal_in, 2)) else $error("alarm bit wrong");
	a_los_status:
		assert property (rd_done && idx == `LSIF_IDX_LINE_STATUS_0
			|-> avs_readdata[0] == $past(rx_line_pair_loss_in, 2)) else $error("loss bit wrong");
	a_status_one_live:
		assert property (rd_done && idx == `LSIF_IDX_LINE_STATUS_1 |-> avs_readdata[7:0] ==
			{2'b00, $past(far_loopback_in, 2), $past(cable_attenuation_in, 2)})
		else $error("second status register wrong");
	a_irq_matches:
		assert property (rd_done && idx == `LSIF_IDX_EVENT_FLAGS_0
			|-> (avs_readdata[7:0] != 8'h00) == $past(irq_req)) else $error("irq differs from flags");
	a_read_high_zero:
		assert property (rd_done |-> avs_readdata[31:8] == 24'h0) else $error("upper read bits set");
	a_write_keeps_data:
		assert property (avs_write && $past(avs_write) |-> $stable(avs_readdata))
		else $error("read data moved during write");
endmodule
////////////////////////////////////////////////////////////////////////////////
bind lsif_line_status_flags lsif_flags_chk #(.LOSS_CYCLES(LOSS_CYCLES)) u_chk (
	.clk(clk), .sys_rst(sys_rst), .avs_address(avs_address), .avs_read(avs_read),
	.avs_write(avs_write), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
	.driver_fault_in(driver_fault_in), .alarm_signal_in(alarm_signal_in),
	.rx_line_pair_loss_in(rx_line_pair_loss_in), .far_loopback_in(far_loopback_in),
	.cable_attenuation_in(cable_attenuation_in), .irq_req(irq_req));

// >>> tb/tb_top.sv
// Self-checking bench for the line status and event flag block.
// Assumes the block answers every register access after one wait state.
`timescale 1ns/1ps
module tb_top;
	reg clk = 0, sys_rst = 1, avs_read = 0, avs_write = 0, far_lb = 0, tx_pin = 0, tx_run = 1;
	reg [9:0] avs_address = 0;
	reg [31:0] avs_writedata = 0, q;
	reg [7:0] cond = 0;
	reg [4:0] atten = 0;
	wire [31:0] avs_readdata;
	wire avs_waitrequest, irq_req;
	integer fail_count = 0, n_checks = 0;
	always #2 clk = ~clk;
	always @(posedge clk) if (tx_run) tx_pin <= ~tx_pin;
	lsif_line_status_flags #(.LOSS_CYCLES(8)) dut (
		.clk(clk), .sys_rst(sys_rst), .avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hf),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
		.driver_fault_in(cond[2]), .alarm_signal_in(cond[1]), .rx_line_pair_loss_in(cond[0]),
		.equalizer_out_of_range_in(cond[7]), .loop_activate_in(cond[6]),
		.loop_deactivate_in(cond[5]), .pattern_sync_in(cond[4]), .far_loopback_in(far_lb),
		.cable_attenuation_in(atten), .tx_clock_pin(tx_pin), .irq_req(irq_req));
	////////////////////////////////////////////////////////////////////////////
	// Each access starts one edge after the last release, so no signal is set twice at once.
	task bus(input wr, input [9:0] a, input [7:0] d);
		begin
			@(posedge clk);
			avs_address <= a;
			avs_write <= wr;
			avs_read <= ~wr;
			avs_writedata <= {24'h0, d};
			@(posedge clk);
			while (avs_waitrequest !== 1'b0) @(posedge clk);
			q = avs_readdata;
			avs_read <= 1'b0;
			avs_write <= 1'b0;
		end
	endtask
	task check(input [31:0] got, input [31:0] exp);
		begin
			n_checks = n_checks + 1;
			if (got !== exp) begin
				$display("unexpected at %0t: got %h expected %h", $time, got, exp);
				fail_count = fail_count + 1;
			end
		end
	endtask
	task rd(input [9:0] a, input [31:0] exp);
		begin
			bus(1'b0, a, 8'h00);
			check(q, exp);
		end
	endtask
	task set(input [7:0] c);
		begin
			@(posedge clk);
			cond <= c;
			repeat (4) @(posedge clk);
		end
	endtask
	task test_done;
		begin
			$display("checks %0d mismatches %0d", n_checks, fail_count);
			if (fail_count == 0 && n_checks > 0) $display("bench passed");
			else $display("bench failed");
			$finish;
		end
	endtask
	////////////////////////////////////////////////////////////////////////////
	initial begin
		#20000;
		fail_count = fail_count + 1;
		test_done;
	end
	initial begin
		repeat (12) @(posedge clk);
		sys_rst <= 1'b0;
		rd(10'h05c, 32'h0);
		rd(10'h060, 32'h0);
		rd(10'h064, 32'h0);
		rd(10'h3fc, 32'h0);
		$display("test reset values done");
		bus(1'b1, 10'h080, 8'h00);
		set(8'hf7);
		rd(10'h05c, 32'hf7);
		@(negedge clk);
		check({31'h0, irq_req}, 32'h1);
		rd(10'h064, 32'hf7);
		rd(10'h064, 32'h0);
		// The clear lands on the taking edge, so the request line is looked at once settled.
		@(negedge clk);
		check({31'h0, irq_req}, 32'h0);
		bus(1'b1, 10'h05c, 8'hff);
		rd(10'h05c, 32'hf7);
		set(8'h00);
		rd(10'h064, 32'h0);
		$display("test rising events done");
		bus(1'b1, 10'h084, 8'hff);
		set(8'hf7);
		rd(10'h064, 32'hf7);
		set(8'h00);
		rd(10'h064, 32'hf7);
		bus(1'b1, 10'h080, 8'hff);
		set(8'hf7);
		rd(10'h064, 32'h0);
		@(negedge clk);
		check({31'h0, irq_req}, 32'h0);
		$display("test edge select and mask done");
		@(posedge clk);
		far_lb <= 1'b1;
		atten <= 5'h16;
		set(8'hf7);
		rd(10'h060, 32'h36);
		$display("test second status done");
		bus(1'b1, 10'h080, 8'h00);
		@(posedge clk);
		tx_run <= 1'b0;
		repeat (20) @(posedge clk);
		rd(10'h05c, 32'hff);
		rd(10'h064, 32'h08);
		tx_run <= 1'b1;
		repeat (6) @(posedge clk);
		rd(10'h05c, 32'hf7);
		$display("test transmit clock loss done");
		test_done;
	end
endmodule
